//--- rtl/pcmh_port.sv
// PCM highway port: slot counting, transmit and receive shifting, registers.
// Assumes the highway master drives the bit clock and frame marker;
// both are sampled by core_clk, so the bit clock must stay well below it.
`timescale 1ns/100ps

// Functional notes
// - Frames of 4 to 128 byte slots, bit clock 256 kHz to 8.192 MHz.
// - Bit clocks of 768 kHz, 1.536 MHz and 1.544 MHz also work.
// - Transmit and receive slots start from separate start counts.
// - A start count beyond the frame length never matches; no transfer.
// - The transmit start count may change at any time.
// - Transmit line is released except during its own sample.
// - A mode bit picks release on falling edge in LSB or next rising edge.
// - Start counts cover long/short marker, IDL2 and B1/B2 slot layouts.
// - Mode field picks A-law, mu-law, 8-bit linear or 16-bit linear.
// - Companded codes: sign, three chord bits, four step bits.
// - Inversion field: even bits, odd bits, all bits, or none, on companded codes.
// - Coding is symmetric; sign bit is zero for negative samples.
// - 16-bit linear is two's complement, sign first, not companded.
// - A 16-bit sample fills two adjacent slots in both directions.
// - 8-bit linear moves bytes without companding.
module pcmh_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Highway pins
  input wire logic bit_clock,
  input wire logic frame_marker,
  input wire logic receive_line,
  output logic transmit_line,
  output logic transmit_line_oe,
  // Register port
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Sample stream
  input wire logic [15:0] txSample,
  output logic txTake,
  output logic [15:0] rxSample,
  output logic rxValid
);
  import pcmh_pkg::*;

  typedef enum logic {TX_IDLE, TX_SHIFT} pcmh_tx_e;
  typedef enum logic {RX_IDLE, RX_SHIFT} pcmh_rx_e;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] mode_r;
  logic [7:0] txLo_r;
  logic [7:0] txHi_r;
  logic [7:0] rxLo_r;
  logic [7:0] rxHi_r;
  logic [7:0] rdData_r;

  wire [1:0] fmt = mode_r[MODE_FMT_LSB +: 2];
  wire [1:0] inv = mode_r[MODE_INV_LSB +: 2];
  wire triOnRise = mode_r[MODE_TRI_BIT];
  wire portEn = mode_r[MODE_EN_BIT];
  wire [START_W-1:0] txStart = {txHi_r[START_HI_BITS-1:0], txLo_r};
  wire [START_W-1:0] rxStart = {rxHi_r[START_HI_BITS-1:0], rxLo_r};
  wire isLin16 = (fmt == FMT_LIN16);
  wire [3:0] slotLast = isLin16 ? LEN16_LAST : LEN8_LAST;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= MODE_RST;
      txLo_r <= START_RST;
      txHi_r <= START_RST;
      rxLo_r <= START_RST;
      rxHi_r <= START_RST;
    end else if (regWrEn) begin
      // Transmit start is live: a new value takes effect at the next match
      case (regAddr)
        MODE_ADDR: mode_r <= regWrData;
        TX_LO_ADDR: txLo_r <= regWrData;
        TX_HI_ADDR: txHi_r <= regWrData;
        // No guard here; changing these during audio is software's burden
        RX_LO_ADDR: rxLo_r <= regWrData;
        RX_HI_ADDR: rxHi_r <= regWrData;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic clkS1_r;
  logic clkS2_r;
  logic clkD_r;
  logic fsS1_r;
  logic fsS2_r;
  logic rxS1_r;
  logic rxS2_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clkS1_r <= 1'b0;
      clkS2_r <= 1'b0;
      clkD_r <= 1'b0;
      fsS1_r <= 1'b0;
      fsS2_r <= 1'b0;
      rxS1_r <= 1'b0;
      rxS2_r <= 1'b0;
    end else begin
      clkS1_r <= bit_clock;
      clkS2_r <= clkS1_r;
      clkD_r <= clkS2_r;
      fsS1_r <= frame_marker;
      fsS2_r <= fsS1_r;
      rxS1_r <= receive_line;
      rxS2_r <= rxS1_r;
    end
  end

  // Any bit clock rate well below core_clk works: only its edges are counted
  wire clkRise = clkS2_r & ~clkD_r;
  wire clkFall = ~clkS2_r & clkD_r;

  // ----------------------------------------
  // Bit clock counter
  // ----------------------------------------
  logic fsPrev_r;
  logic [CNT_W-1:0] bitCnt_r;
  logic frameSeen_r;

  wire frameStart = clkRise & fsS2_r & ~fsPrev_r;
  // Saturating count: a start beyond the frame never matches
  wire [CNT_W-1:0] bitCntNxt = frameStart ? '0 :
                               (bitCnt_r == CNT_MAX) ? CNT_MAX :
                               CNT_W'(bitCnt_r + 1'b1);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fsPrev_r <= 1'b0;
      bitCnt_r <= CNT_MAX;
      frameSeen_r <= 1'b0;
    end else if (clkRise) begin
      fsPrev_r <= fsS2_r;
      bitCnt_r <= bitCntNxt;
      frameSeen_r <= frameSeen_r | frameStart;
    end
  end

  // Marker-to-data offset is all in the start count
  wire txMatch = clkRise & portEn & (bitCntNxt == {1'b0, txStart});
  wire rxMatch = clkRise & portEn & (bitCntNxt == {1'b0, rxStart});

  // ----------------------------------------
  // Sample coder
  // ----------------------------------------
  pcmh_codec_if cif ();
  logic [15:0] rxShift_r;

  assign cif.fmt = fmt;
  assign cif.inv = inv;
  assign cif.txLin = txSample;
  assign cif.rxWord = isLin16 ? rxShift_r : {rxShift_r[7:0], 8'h00};

  pcmh_codec uCodec (
    .cif(cif.coder)
  );

  // ----------------------------------------
  // Transmit shifter
  // ----------------------------------------
  pcmh_tx_e txState_r;
  logic [15:0] txShift_r;
  logic [3:0] txLeft_r;
  logic txBit_r;
  logic txOe_r;

  wire txStartNow = txMatch & (txState_r == TX_IDLE);
  wire txLast = (txState_r == TX_SHIFT) & (txLeft_r == 4'h0);
  // Falling release lets a neighbour drive the next slot without overlap
  wire txRelFall = txLast & clkFall & ~triOnRise;
  wire txRelRise = txLast & clkRise & triOnRise;
  wire txAdvance = (txState_r == TX_SHIFT) & clkRise & ~txLast;

  assign txTake = txStartNow;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txState_r <= TX_IDLE;
      txShift_r <= 16'h0000;
      txLeft_r <= 4'h0;
      txBit_r <= 1'b0;
      txOe_r <= 1'b0;
    end else begin
      case (txState_r)
        TX_IDLE: begin
          if (txStartNow) begin
            txShift_r <= {cif.txWord[14:0], 1'b0};
            txBit_r <= cif.txWord[15];
            txLeft_r <= slotLast;
            txOe_r <= 1'b1;
            txState_r <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (txRelFall || txRelRise) begin
            txOe_r <= 1'b0;
            txState_r <= TX_IDLE;
          end else if (txAdvance) begin
            txBit_r <= txShift_r[15];
            txShift_r <= {txShift_r[14:0], 1'b0};
            txLeft_r <= 4'(txLeft_r - 1'b1);
          end
        end
        default: txState_r <= TX_IDLE;
      endcase
    end
  end

  assign transmit_line = txBit_r;
  assign transmit_line_oe = txOe_r;

  // ----------------------------------------
  // Receive shifter
  // ----------------------------------------
  pcmh_rx_e rxState_r;
  logic [3:0] rxLeft_r;
  logic rxDone_r;
  logic rxValid_r;
  logic [15:0] rxSample_r;

  // Data and bit clock share the same sync delay, so the fall stays aligned
  wire rxSampleNow = (rxState_r == RX_SHIFT) & clkFall;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxState_r <= RX_IDLE;
      rxShift_r <= 16'h0000;
      rxLeft_r <= 4'h0;
      rxDone_r <= 1'b0;
    end else begin
      rxDone_r <= 1'b0;
      case (rxState_r)
        RX_IDLE: begin
          if (rxMatch) begin
            rxLeft_r <= slotLast;
            rxState_r <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (rxSampleNow) begin
            rxShift_r <= {rxShift_r[14:0], rxS2_r};
            rxLeft_r <= 4'(rxLeft_r - 1'b1);
            if (rxLeft_r == 4'h0) begin
              rxDone_r <= 1'b1;
              rxState_r <= RX_IDLE;
            end
          end
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxValid_r <= 1'b0;
      rxSample_r <= 16'h0000;
    end else begin
      rxValid_r <= rxDone_r;
      if (rxDone_r) rxSample_r <= cif.rxLin;
    end
  end

  assign rxValid = rxValid_r;
  assign rxSample = rxSample_r;

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  wire [7:0] statusWord = {5'h00, frameSeen_r, rxState_r == RX_SHIFT, txOe_r};
  wire [7:0] rdMux = (regAddr == MODE_ADDR) ? mode_r :
                     (regAddr == TX_LO_ADDR) ? txLo_r :
                     (regAddr == TX_HI_ADDR) ? txHi_r :
                     (regAddr == RX_LO_ADDR) ? rxLo_r :
                     (regAddr == RX_HI_ADDR) ? rxHi_r :
                     (regAddr == STAT_ADDR) ? statusWord : 8'h00;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) rdData_r <= 8'h00;
    else rdData_r <= rdMux;
  end

  assign regRdData = rdData_r;

endmodule : pcmh_port

//--- rtl/pcmh_pkg.sv
// Constants shared by the PCM highway port and its sample coder.
// Assumes the register port carries 8-bit data and 8-bit addresses.
package pcmh_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] MODE_ADDR = 8'h35;
  localparam logic [7:0] TX_LO_ADDR = 8'h36;
  localparam logic [7:0] TX_HI_ADDR = 8'h37;
  localparam logic [7:0] RX_LO_ADDR = 8'h38;
  localparam logic [7:0] RX_HI_ADDR = 8'h39;
  localparam logic [7:0] STAT_ADDR = 8'h3A;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int MODE_FMT_LSB = 0;
  localparam int MODE_INV_LSB = 2;
  localparam int MODE_TRI_BIT = 4;
  localparam int MODE_EN_BIT = 5;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] START_RST = 8'h00;
  localparam int START_HI_BITS = 3;
  localparam int START_W = 11;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;

  // ----------------------------------------
  // Sample formats and inversion choices
  // ----------------------------------------
  localparam logic [1:0] FMT_BIT_INVERSION_FIELD = 2'h0;
  localparam logic [1:0] FMT_MULAW = 2'h1;
  localparam logic [1:0] FMT_LIN8 = 2'h2;
  localparam logic [1:0] FMT_LIN16 = 2'h3;
  localparam logic [1:0] INV_NONE = 2'h0;
  localparam logic [1:0] INV_EVEN = 2'h1;
  localparam logic [1:0] INV_ALL = 2'h2;
  localparam logic [1:0] INV_ODD = 2'h3;
  localparam logic [7:0] MASK_EVEN = 8'h55;
  localparam logic [7:0] MASK_ODD = 8'hAA;
  localparam logic [7:0] MASK_ALL = 8'hFF;

  // ----------------------------------------
  // Slot lengths, counted in bit clocks
  // ----------------------------------------
  localparam logic [3:0] LEN8_LAST = 4'h7;
  localparam logic [3:0] LEN16_LAST = 4'hF;

endpackage : pcmh_pkg

//--- rtl/pcmh_codec_if.sv
// Carrier between the highway port and its sample coder.
// Words are left aligned: 8-bit codes sit in bits 15:8.
`timescale 1ns/100ps
interface pcmh_codec_if;
  logic [1:0] fmt;
  logic [1:0] inv;
  logic [15:0] txLin;
  logic [15:0] txWord;
  logic [15:0] rxWord;
  logic [15:0] rxLin;
  modport port (output fmt, output inv, output txLin, input txWord, output rxWord,
    input rxLin);
  modport coder (input fmt, input inv, input txLin, output txWord, input rxWord,
    output rxLin);
endinterface : pcmh_codec_if

//--- rtl/pcmh_codec.sv
// Combinational sample coder: linear to line word and back.
// Assumes 16-bit two's complement linear samples on the user side.
`timescale 1ns/100ps
module pcmh_codec (
  // Coder side of the carrier
  pcmh_codec_if.coder cif
);
  import pcmh_pkg::*;

  function automatic logic [16:0] absVal(input logic [15:0] s);
    absVal = s[15] ? 17'((~{1'b0, s}) + 17'h1_0000 + 17'h0_0001) : {1'b0, s};
  endfunction : absVal

  // Segmented codes: sign, three chord bits, four step bits
  function automatic logic [7:0] muEnc(input logic [15:0] s);
    logic [16:0] a;
    logic [14:0] m;
    logic [2:0] seg;
    a = absVal(s);
    m = a[16:2] > 15'd8158 ? 15'd8158 : a[16:2];
    m = 15'(m + 15'd33);
    seg = 3'd0;
    for (int i = 0; i < 8; i++) begin
      if (m[i+5]) seg = 3'(i);
    end
    // Shift widened to 4 bits: chord 7 needs a shift of 8, not a wrap to 0
    muEnc = {~s[15], seg, 4'(m >> (4'(seg) + 4'd1))};
  endfunction : muEnc

  function automatic logic [7:0] aEnc(input logic [15:0] s);
    logic [16:0] a;
    logic [13:0] m;
    logic [2:0] seg;
    a = absVal(s);
    m = a[16:3] > 14'd4095 ? 14'd4095 : a[16:3];
    seg = 3'd0;
    for (int i = 1; i < 8; i++) begin
      if (m[i+4]) seg = 3'(i);
    end
    aEnc = {~s[15], seg, (seg == 3'd0) ? m[4:1] : 4'(m >> seg)};
  endfunction : aEnc

  function automatic logic [15:0] muDec(input logic [7:0] c);
    logic [15:0] t;
    t = 16'(({9'h000, c[3:0], 3'h0} + 16'd132) << c[6:4]);
    t = 16'(t - 16'd132);
    muDec = c[7] ? t : 16'(-t);
  endfunction : muDec

  function automatic logic [15:0] aDec(input logic [7:0] c);
    logic [15:0] t;
    t = 16'({8'h00, c[3:0], 4'h0} + ((c[6:4] == 3'd0) ? 16'd8 : 16'd264));
    if (c[6:4] > 3'd1) t = 16'(t << (c[6:4] - 3'd1));
    aDec = c[7] ? t : 16'(-t);
  endfunction : aDec

  // ----------------------------------------
  // Inversion applies to companded codes only
  // ----------------------------------------
  wire [7:0] invMask = (cif.inv == INV_EVEN) ? MASK_EVEN :
                       (cif.inv == INV_ALL) ? MASK_ALL :
                       (cif.inv == INV_ODD) ? MASK_ODD : 8'h00;
  wire [7:0] rxCode = cif.rxWord[15:8] ^ invMask;

  // ----------------------------------------
  // Format selection
  // ----------------------------------------
  assign cif.txWord = (cif.fmt == FMT_BIT_INVERSION_FIELD) ? {aEnc(cif.txLin) ^ invMask, 8'h00} :
                      (cif.fmt == FMT_MULAW) ? {muEnc(cif.txLin) ^ invMask, 8'h00} :
                      (cif.fmt == FMT_LIN8) ? {cif.txLin[15:8], 8'h00} :
                      cif.txLin;
  assign cif.rxLin = (cif.fmt == FMT_BIT_INVERSION_FIELD) ? aDec(rxCode) :
                     (cif.fmt == FMT_MULAW) ? muDec(rxCode) :
                     (cif.fmt == FMT_LIN8) ? {cif.rxWord[15:8], 8'h00} :
                     cif.rxWord;

endmodule : pcmh_codec

//--- verification/pcmh_hwy_master.sv
// Highway master model: bit clock, frame marker, receive data, capture.
// Assumes a 32-bit frame; the transmit line has a pull-down.
`timescale 1ns/100ps
module pcmh_hwy_master (
  // Device pins
  input wire logic core_clk,
  input wire logic txLine,
  input wire logic txOe,
  input wire logic txTake,
  input wire logic rxValid,
  output logic bitClk,
  output logic frameMarker,
  output logic rxLine,
  // Bench side
  input wire logic [31:0] rxPat,
  output logic [15:0] lastTx,
  output logic [5:0] lastBits,
  output logic [5:0] lastPos,
  output logic [9:0] lastOeCyc,
  output logic [1:0] lastTakes,
  output logic [1:0] lastValids
);
  logic [15:0] txCap = 0;
  logic [5:0] nBits = 0;
  logic [5:0] pos = 0;
  logic [9:0] oeCyc = 0;
  logic [1:0] takes = 0;
  logic [1:0] valids = 0;
  // Released line settles low through the pull-down
  wire txWire = txOe ? txLine : 1'b0;
  initial begin
    bitClk = 0;
    frameMarker = 0;
    rxLine = 0;
    // Four byte slots; the bench's placements always leave one slot free
    forever for (int i = 0; i < 32; i++) begin
      #80 bitClk = 1;
      rxLine = rxPat[31-i];
      #80 bitClk = 0;
      if (txOe) begin
        if (nBits == 0) pos = i[5:0];
        txCap = {txCap[14:0], txWire};
        nBits++;
      end
      frameMarker = (i == 31);
    end
  end
  always @(posedge core_clk) begin
    oeCyc += txOe;
    takes += txTake;
    valids += rxValid;
  end
  always @(posedge frameMarker) begin
    lastTx = txCap;
    lastBits = nBits;
    lastPos = pos;
    lastOeCyc = oeCyc;
    lastTakes = takes;
    lastValids = valids;
    txCap = 0;
    nBits = 0;
    oeCyc = 0;
    takes = 0;
    valids = 0;
  end
endmodule : pcmh_hwy_master

//--- verification/pcmh_port_monitor.sv
// Pin-level checks on the highway port.
// Assumes a bit clock of 40 core_clk periods, as the bench makes it.
`timescale 1ns/100ps
module pcmh_port_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Highway and stream
  input wire logic bit_clock,
  input wire logic transmit_line,
  input wire logic transmit_line_oe,
  input wire logic txTake,
  input wire logic rxValid
);
  logic [9:0] oeCnt_r;
  logic [3:0] edgeAge_r;
  logic clkPrev_r;
  wire [9:0] oeCnt_nxt = transmit_line_oe ? oeCnt_r + 10'd1 : 10'd0;
  wire [3:0] edgeAge_nxt = (bit_clock != clkPrev_r) ? 4'd0 :
    (edgeAge_r == 4'd15) ? 4'd15 : edgeAge_r + 4'd1;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      oeCnt_r <= '0;
      edgeAge_r <= '0;
      clkPrev_r <= 1'b0;
    end else begin
      oeCnt_r <= oeCnt_nxt;
      edgeAge_r <= edgeAge_nxt;
      clkPrev_r <= bit_clock;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_take_drives: assert property (txTake |-> ##[0:3] transmit_line_oe)
    else $error("transmit enable missing after take");
  a_oe_from_take: assert property ($rose(transmit_line_oe) |->
    txTake || $past(txTake) || $past(txTake, 2)) else $error("enable without take");
  a_oe_hold: assert property ($fell(transmit_line_oe) |->
    oeCnt_r inside {[296:324], [616:644]}) else $error("enable length wrong");
  a_take_idle: assert property (txTake |-> !$past(transmit_line_oe))
    else $error("take while slot shifts");
  a_take_single: assert property (txTake |=> !txTake)
    else $error("take longer than a cycle");
  a_rx_single: assert property (rxValid |=> !rxValid [*8])
    else $error("receive valid repeated");
  a_bit_timing: assert property (transmit_line_oe && $past(transmit_line_oe) &&
    $changed(transmit_line) |-> edgeAge_r <= 4'd7) else $error("bit off clock edge");
  a_release_edge: assert property ($fell(transmit_line_oe) |-> edgeAge_r <= 4'd7)
    else $error("release off clock edge");
  cover property ($fell(transmit_line_oe));
  cover property (txTake);
  cover property (rxValid);
endmodule : pcmh_port_monitor
bind pcmh_port pcmh_port_monitor mon_u (.core_clk, .resetn, .bit_clock, .transmit_line,
  .transmit_line_oe, .txTake, .rxValid);

//--- verification/tb_pcm_highway_companding_port.sv
// Self-checking bench for the highway port.
// Assumes the master model runs a 32-bit frame on a 160 ns bit clock.
`timescale 1ns/100ps
module tb_pcm_highway_companding_port;
  import pcmh_pkg::*;
  logic core_clk = 0;
  logic resetn = 0;
  logic bitClk, frameMarker, rxLine, txLine, txOe, txTake, rxValid;
  logic regWrEn = 0;
  logic [7:0] regAddr = 0;
  logic [7:0] regWrData = 0;
  logic [7:0] regRdData;
  logic [15:0] txSample = 0;
  logic [15:0] rxSample, lastTx;
  logic [31:0] rxPat = 0;
  logic [5:0] lastBits, lastPos;
  logic [9:0] lastOeCyc;
  logic [1:0] lastTakes, lastValids;
  int errors = 0;
  int nTests = 0;
  always #2 core_clk = ~core_clk;
  pcmh_port dut_u (.core_clk, .resetn, .bit_clock(bitClk), .frame_marker(frameMarker),
    .receive_line(rxLine), .transmit_line(txLine), .transmit_line_oe(txOe), .regWrEn,
    .regAddr, .regWrData, .regRdData, .txSample, .txTake, .rxSample, .rxValid);
  pcmh_hwy_master hwy_u (.core_clk, .txLine, .txOe, .txTake, .rxValid, .bitClk,
    .frameMarker, .rxLine, .rxPat, .lastTx, .lastBits, .lastPos, .lastOeCyc,
    .lastTakes, .lastValids);
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk) #1;
    regWrEn = 1;
    regAddr = a;
    regWrData = d;
    @(posedge core_clk) #1;
    regWrEn = 0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk) #1;
    regAddr = a;
    repeat (2) @(posedge core_clk);
    #1 check("regRdData", {8'h00, exp}, {8'h00, regRdData});
  endtask : rd
  task automatic frames(int n);
    repeat (n) @(posedge frameMarker);
    // A slot ending on the last bit lands in rxSample a few cycles after the marker
    repeat (30) @(posedge core_clk);
    #1;
  endtask : frames
  function automatic logic [7:0] md(logic [1:0] f, logic [1:0] v, logic t);
    return {2'b00, 1'b1, t, v, f};
  endfunction : md
  // Disable, place both slots, enable, then let one whole frame pass
  task automatic cfg(logic [7:0] m, logic [10:0] txs, logic [10:0] rxs);
    wr(MODE_ADDR, MODE_RST);
    wr(RX_LO_ADDR, rxs[7:0]);
    wr(RX_HI_ADDR, {5'h00, rxs[10:8]});
    wr(TX_LO_ADDR, txs[7:0]);
    wr(TX_HI_ADDR, {5'h00, txs[10:8]});
    wr(MODE_ADDR, m);
    frames(2);
  endtask : cfg
  task automatic t_regs;
    for (int a = 0; a < 4; a++) begin
      rd(TX_LO_ADDR + a[7:0], START_RST);
      wr(TX_LO_ADDR + a[7:0], 8'hF0 + a[7:0]);
    end
    for (int a = 0; a < 4; a++) rd(TX_LO_ADDR + a[7:0], 8'hF0 + a[7:0]);
    rd(8'h40, 8'h00);
  endtask : t_regs
  task automatic t_lin8;
    txSample = 16'hA53C;
    rxPat = 32'h0000_C300;
    cfg(md(FMT_LIN8, INV_NONE, 1'b0), 11'd8, 11'd16);
    check("txByte", 16'h00A5, lastTx);
    check("txBits", 16'd8, {10'd0, lastBits});
    check("txPos", 16'd8, {10'd0, lastPos});
    check("rxSample", 16'hC300, rxSample);
    check("oeFall", 16'd1, {15'd0, lastOeCyc inside {[296:304]}});
    check("takes", 16'd1, {14'd0, lastTakes});
    check("valids", 16'd1, {14'd0, lastValids});
    wr(TX_LO_ADDR, 8'd24);
    frames(2);
    check("txPos", 16'd24, {10'd0, lastPos});
    wr(MODE_ADDR, md(FMT_LIN8, INV_NONE, 1'b1));
    frames(2);
    check("oeRise", 16'd1, {15'd0, lastOeCyc inside {[316:324]}});
    cfg(md(FMT_LIN8, INV_NONE, 1'b0), 11'd40, 11'd40);
    check("txBits", 16'd0, {10'd0, lastBits});
    check("valids", 16'd0, {14'd0, lastValids});
  endtask : t_lin8
  task automatic t_lin16;
    txSample = 16'h8123;
    rxPat = 32'h0000_9A5C;
    cfg(md(FMT_LIN16, INV_EVEN, 1'b0), 11'd8, 11'd16);
    check("txWord", 16'h8123, lastTx);
    check("txBits", 16'd16, {10'd0, lastBits});
    check("rxSample", 16'h9A5C, rxSample);
  endtask : t_lin16
  task automatic t_comp;
    logic [7:0] mask [4] = '{8'h00, MASK_EVEN, MASK_ALL, MASK_ODD};
    for (int f = 0; f < 2; f++) begin
      for (int v = 0; v < 4; v++) begin
        txSample = 16'h7FFF;
        rxPat = {16'h0000, 8'h7F ^ mask[v], 8'h00};
        cfg(md(f[1:0], v[1:0], 1'b0), 11'd8, 11'd16);
        check("codePos", {8'h00, 8'hFF ^ mask[v]}, lastTx);
        check("rxSign", 16'd1, {15'd0, rxSample[15]});
        txSample = 16'h8000;
        frames(1);
        check("codeNeg", {8'h00, 8'h7F ^ mask[v]}, lastTx);
      end
    end
  endtask : t_comp
  task automatic results;
    $display("checks %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge core_clk);
    #1 resetn = 1;
    t_regs();
    t_lin8();
    t_lin16();
    t_comp();
    results();
  end
  // Some 34 frames of 5.12 us are needed; this leaves ample margin
  initial begin
    #300_000;
    errors++;
    results();
  end
endmodule : tb_pcm_highway_companding_port
